// ===== hdl/adcpp_conv_if.sv
// Signals between the port logic and the conversion sequencer
interface adcpp_conv_if;
    logic start;     // Convert-start falling edge, one cycle
    logic clk_rise;  // Conversion clock rising edge, one cycle
    logic load;      // 13th edge: load result, one cycle
    logic finish;    // Busy has just fallen, one cycle
    logic busy;      // Conversion in progress
    logic track;     // Sampler tracking when high

    modport port_side (output start, output clk_rise, input load, input finish,
                       input busy, input track);
    modport seq_side  (input start, input clk_rise, output load, output finish,
                       output busy, output track);
endinterface

// ===== hdl/adcpp_defines.svh
// Constants for the parallel-port conversion controller
`ifndef ADCPP_DEFINES_SVH
`define ADCPP_DEFINES_SVH

`define ADCPP_BUS_W        12
`define ADCPP_CTRL_RST     12'h000
`define ADCPP_CONV_EDGES   4'hD
`define ADCPP_CLK_MHZ      25
`define ADCPP_T2_NS        40
// Tail after the last conversion edge, rounded up, never below one cycle
`define ADCPP_TAIL_CYC     (((`ADCPP_T2_NS * `ADCPP_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
                            ((`ADCPP_T2_NS * `ADCPP_CLK_MHZ + 999) / 1000))
`define ADCPP_LOW_LSB      0
`define ADCPP_LOW_MSB      7
`define ADCPP_UPPER_MSB    11
`define ADCPP_UPPER_LSB    8
`define ADCPP_NIB_MSB      3
`define ADCPP_CHAN_LSB     4
`define ADCPP_CHAN_MSB     5
`define ADCPP_PIN8         8
`define ADCPP_OE_BYTE      12'h0FF
`define ADCPP_OE_WORD      12'hFFF

`endif

// ===== hdl/adcpp_pkg.sv
// Types shared by the conversion controller modules
package adcpp_pkg;
    typedef enum logic [1:0] {
        ADCPP_IDLE,
        ADCPP_CONV,
        ADCPP_TAIL
    } adcpp_state_t;
endpackage

// ===== hdl/adcpp_port_ctrl.sv
// Parallel host port and conversion control of a four-channel converter
`include "adcpp_defines.svh"

module adcpp_port_ctrl #(
    parameter int RESULT_BITS = 12,
    parameter int TAIL_CYC    = `ADCPP_TAIL_CYC
) (
    input  wire logic        sys_clk,              // System clock, 25 MHz
    input  wire logic        reset_n,              // Asynchronous reset, active low
    input  wire logic        word_mode,            // Word/byte select pin
    input  wire logic        chip_select_n,        // Chip select pin
    input  wire logic        read_n,               // Read strobe pin
    input  wire logic        write_n,              // Write strobe pin
    input  wire logic        convert_start_n,      // Convert-start pin
    input  wire logic        conversion_clock_in,  // Conversion clock pin
    input  wire logic        auto_powerdown_mode,  // Auto shutdown/standby selected
    input  wire logic [11:0] data_in,              // Data pins, input side
    output logic      [11:0] data_out,             // Data pins, output side
    output logic      [11:0] data_oe,              // Data pin enables, high drives
    input  wire logic [11:0] conv_result_in,       // Analog core code, left aligned
    input  wire logic [1:0]  conv_channel_in,      // Channel of the code
    output logic             busy,                 // Busy pin
    output logic             sampler_track,        // High tracks, low holds
    output logic             powered_down,         // Analog core powered down
    output logic      [11:0] control_word          // Control register contents
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = 18;
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] meta_reg, meta_next;
    logic [SW-1:0] sync_reg, sync_next;
    logic [SW-1:0] prev_reg, prev_next;

    assign pins_raw = {conversion_clock_in, convert_start_n, write_n, read_n,
                       chip_select_n, word_mode, data_in};

    // First stage feeds only the second; edges use the second and third
    always_comb begin
        meta_next = pins_raw;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 18'h3F000;
            sync_reg <= 18'h3F000;
            prev_reg <= 18'h3F000;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    logic [11:0] bus_s;
    logic        wmode_s, cs_n_s, rd_n_s, wr_n_s, cst_n_s, cclk_s;
    logic        cst_n_p, cclk_p, wr_n_p, upper_s;
    assign {cclk_s, cst_n_s, wr_n_s, rd_n_s, cs_n_s, wmode_s, bus_s} = sync_reg;
    assign cclk_p  = prev_reg[17];
    assign cst_n_p = prev_reg[16];
    assign wr_n_p  = prev_reg[15];
    assign upper_s = bus_s[`ADCPP_PIN8];  // pin 8 read as enable in byte mode

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    adcpp_conv_if cv ();
    assign cv.start    = cst_n_p & ~cst_n_s;
    assign cv.clk_rise = ~cclk_p & cclk_s;

    adcpp_sequencer #(
        .TAIL_CYC (TAIL_CYC)
    ) u_seq (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .cv      (cv.seq_side)
    );

    // ------------------------------------------------------------
    // Read data shaping
    // ------------------------------------------------------------
    // Ten-bit parts clear the bits below the result
    localparam logic [11:0] RES_MASK = 12'(12'hFFF << (12 - RESULT_BITS));

    // Bus value for a read in the current mode
    function automatic logic [11:0] read_word(input logic wm, input logic up,
                                              input logic [11:0] r, input logic [1:0] ch);
        logic [11:0] w;
        w = 12'h000;
        if (wm)
            w = r;
        else if (!up)
            w[`ADCPP_LOW_MSB:`ADCPP_LOW_LSB] = r[`ADCPP_LOW_MSB:`ADCPP_LOW_LSB];
        else begin
            w[`ADCPP_NIB_MSB:0] = r[`ADCPP_UPPER_MSB:`ADCPP_UPPER_LSB];
            w[`ADCPP_CHAN_MSB:`ADCPP_CHAN_LSB] = ch;
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Result, control and port registers
    // ------------------------------------------------------------
    logic [11:0] result_reg, result_next;
    logic [1:0]  chan_reg, chan_next;
    logic [11:0] ctrl_reg, ctrl_next;
    logic [11:0] dout_reg, dout_next;
    logic [11:0] oe_reg, oe_next;
    logic        pd_reg, pd_next;
    logic        rd_sel, wr_done, wake;

    assign rd_sel  = ~cs_n_s & ~rd_n_s;
    // Capture on the strobe's rising edge, when host data has settled
    assign wr_done = ~cs_n_s & ~wr_n_p & wr_n_s;
    assign wake    = ~cst_n_p & cst_n_s;

    always_comb begin
        result_next = result_reg;
        chan_next   = chan_reg;
        ctrl_next   = ctrl_reg;
        pd_next     = pd_reg;
        if (cv.load) begin
            result_next = conv_result_in & RES_MASK;
            chan_next   = conv_channel_in;
        end
        if (wr_done) begin
            if (wmode_s)
                ctrl_next = bus_s;
            else if (!upper_s)
                ctrl_next[`ADCPP_LOW_MSB:`ADCPP_LOW_LSB] =
                    bus_s[`ADCPP_LOW_MSB:`ADCPP_LOW_LSB];
            else
                ctrl_next[`ADCPP_UPPER_MSB:`ADCPP_UPPER_LSB] =
                    bus_s[`ADCPP_NIB_MSB:0];            // lines 4-7 unused
        end
        // Rising convert-start wakes; a new power-down wins a same-cycle wake
        if (wake && auto_powerdown_mode)
            pd_next = 1'b0;
        if (cv.finish && auto_powerdown_mode)
            pd_next = 1'b1;
        // Drive only while selected for read; pin 8 stays input in byte mode
        oe_next   = rd_sel ? (wmode_s ? `ADCPP_OE_WORD : `ADCPP_OE_BYTE) : 12'h000;
        dout_next = rd_sel ? read_word(wmode_s, upper_s, result_reg, chan_reg) : 12'h000;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= 12'h000;
            chan_reg   <= 2'h0;
            ctrl_reg   <= `ADCPP_CTRL_RST;
            dout_reg   <= 12'h000;
            oe_reg     <= 12'h000;
            pd_reg     <= 1'b0;
        end else begin
            result_reg <= result_next;
            chan_reg   <= chan_next;
            ctrl_reg   <= ctrl_next;
            dout_reg   <= dout_next;
            oe_reg     <= oe_next;
            pd_reg     <= pd_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out      = dout_reg;
    assign data_oe       = oe_reg;
    assign busy          = cv.busy;
    assign sampler_track = cv.track;
    assign powered_down  = pd_reg;
    assign control_word  = ctrl_reg;
endmodule

// ===== hdl/adcpp_sequencer.sv
// Conversion sequencer: counts conversion clock edges and times busy
`include "adcpp_defines.svh"

module adcpp_sequencer #(
    parameter int TAIL_CYC = `ADCPP_TAIL_CYC
) (
    input  wire logic      sys_clk,  // System clock
    input  wire logic      reset_n,  // Asynchronous reset, active low
    adcpp_conv_if.seq_side cv        // Link to the port logic
);
    adcpp_pkg::adcpp_state_t state_reg, state_next;
    logic [3:0]  edge_reg, edge_next;
    logic [7:0]  tail_reg, tail_next;
    logic        busy_reg, busy_next;
    logic        track_reg, track_next;
    logic        load_reg, load_next;
    logic        fin_reg, fin_next;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Only counted edges advance the count, so a burst clock that stops
    // between conversions is as good as a free-running one
    always_comb begin
        state_next = state_reg;
        edge_next  = edge_reg;
        tail_next  = tail_reg;
        busy_next  = busy_reg;
        track_next = track_reg;
        load_next  = 1'b0;
        fin_next   = 1'b0;
        case (state_reg)
            adcpp_pkg::ADCPP_IDLE: begin
                if (cv.start) begin
                    state_next = adcpp_pkg::ADCPP_CONV;
                    edge_next  = 4'h0;
                    busy_next  = 1'b1;
                    track_next = 1'b0;
                end
            end
            adcpp_pkg::ADCPP_CONV: begin
                if (cv.clk_rise) begin
                    edge_next = edge_reg + 4'h1;
                    if (edge_reg + 4'h1 == `ADCPP_CONV_EDGES) begin
                        track_next = 1'b1;
                        load_next  = 1'b1;
                        tail_next  = 8'h00;
                        state_next = adcpp_pkg::ADCPP_TAIL;
                    end
                end
            end
            adcpp_pkg::ADCPP_TAIL: begin
                tail_next = tail_reg + 8'h01;
                if (tail_reg == 8'(TAIL_CYC - 1)) begin
                    busy_next  = 1'b0;
                    fin_next   = 1'b1;
                    state_next = adcpp_pkg::ADCPP_IDLE;
                end
            end
            default: begin
                state_next = adcpp_pkg::ADCPP_IDLE;
                busy_next  = 1'b0;
                track_next = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= adcpp_pkg::ADCPP_IDLE;
            edge_reg  <= 4'h0;
            tail_reg  <= 8'h00;
            busy_reg  <= 1'b0;
            track_reg <= 1'b1;
            load_reg  <= 1'b0;
            fin_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            edge_reg  <= edge_next;
            tail_reg  <= tail_next;
            busy_reg  <= busy_next;
            track_reg <= track_next;
            load_reg  <= load_next;
            fin_reg   <= fin_next;
        end
    end

    assign cv.busy   = busy_reg;
    assign cv.track  = track_reg;
    assign cv.load   = load_reg;
    assign cv.finish = fin_reg;
endmodule

// ===== test/adcpp_host_model.sv
// Host bus model: strobes, data pins and the bursting conversion clock
module adcpp_host_model (
    input  logic        sys_clk,             // System clock
    input  logic [11:0] data_out,            // Device data drive
    input  logic [11:0] data_oe,             // Device data enables
    output logic        word_mode,           // Word/byte select
    output logic        chip_select_n,       // Chip select
    output logic        read_n,              // Read strobe
    output logic        write_n,             // Write strobe
    output logic        convert_start_n,     // Convert start
    output logic        conversion_clock_in, // Conversion clock, idles low
    output logic [11:0] data_in              // Resolved data pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] host_d; // Host drive, inverted on release so stale data never matches
    // ----------------------------------------
    // Pin resolution: device value where it drives, else the host's
    // ----------------------------------------
    assign data_in = (data_oe & data_out) | (~data_oe & host_d);
    initial begin
        {word_mode, chip_select_n, read_n, write_n, convert_start_n, conversion_clock_in} = 6'h3E;
        host_d = 12'h000;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Mode settles through the device synchronisers before the strobe
    task automatic xfer(input logic wm, input logic wr, input logic [11:0] d,
                        output logic [11:0] q);
        word_mode = wm;
        host_d = wr ? d : {~host_d[11:9], d[8], ~host_d[7:0]};
        wait_cyc(3);
        chip_select_n = 1'b0;
        read_n = wr;
        write_n = !wr;
        wait_cyc(5);
        q = data_out;
        write_n = 1'b1;
        read_n = 1'b1;
        wait_cyc(4);
        chip_select_n = 1'b1;
        host_d = ~host_d;
        wait_cyc(4);
    endtask
    // Clock only runs in bursts, standing low between them
    task automatic clk_rises(input int n, input int half);
        repeat (n) begin
            wait_cyc(half);
            conversion_clock_in = 1'b1;
            wait_cyc(half);
            conversion_clock_in = 1'b0;
        end
    endtask
    task automatic set_start(input logic v);
        convert_start_n = v;
    endtask
endmodule

// ===== test/adcpp_port_checker.sv
// Concurrent checks on the pins of the parallel-port conversion controller
module adcpp_port_checker #(
    parameter int TAIL_CYC = 1
) (
    input logic        sys_clk,             // System clock
    input logic        reset_n,             // Reset, active low
    input logic        word_mode,           // Word/byte select
    input logic        chip_select_n,       // Chip select
    input logic        read_n,              // Read strobe
    input logic        convert_start_n,     // Convert start
    input logic        auto_powerdown_mode, // Auto power-down selected
    input logic [11:0] data_in,             // Resolved data pins
    input logic [11:0] data_out,            // Device data drive
    input logic [11:0] data_oe,             // Device data enables
    input logic        busy,                // Busy pin
    input logic        sampler_track,       // Sampler tracking
    input logic        powered_down,        // Core powered down
    input logic [11:0] control_word         // Control register
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Steps of a transfer, long enough to pass the pin synchronisers
    // ----------------------------------------
    sequence s_idle_bus;  (chip_select_n || read_n) [*4]; endsequence
    sequence s_word_rd;   (!chip_select_n && !read_n && word_mode) [*4]; endsequence
    sequence s_byte_rd;   (!chip_select_n && !read_n && !word_mode) [*4]; endsequence
    sequence s_upper_rd;  (!chip_select_n && !read_n && !word_mode && data_in[8]) [*4]; endsequence
    // Track returns, then busy stays up for the fixed tail and falls
    sequence s_conv_end;  busy ##TAIL_CYC !busy; endsequence
    chk_start_busy: assert property ($fell(convert_start_n) && !busy && !powered_down |->
        ##[1:4] busy) else $error("busy late after start");
    chk_hold_on_busy: assert property ($rose(busy) |-> !sampler_track)
        else $error("sampler not holding at busy");
    chk_busy_after_load: assert property ($fell(busy) |-> $past(sampler_track, TAIL_CYC))
        else $error("busy fell before result load");
    chk_track_end: assert property ($rose(sampler_track) |-> s_conv_end)
        else $error("busy end out of step with track");
    chk_bus_float: assert property (s_idle_bus |-> data_oe == 12'h000 && data_out == 12'h000)
        else $error("data pins driven outside a read");
    chk_word_read: assert property (s_word_rd |-> data_oe == 12'hFFF)
        else $error("word read enables wrong");
    chk_byte_read: assert property (s_byte_rd |-> data_oe == 12'h0FF)
        else $error("byte read enables wrong");
    chk_upper_zero: assert property (s_upper_rd |-> data_out[7:6] == 2'b00)
        else $error("upper byte top bits not zero");
    chk_ctrl_cs: assert property (!$stable(control_word) |-> !$past(chip_select_n, 3))
        else $error("control changed without chip select");
    chk_pd_wake: assert property ($rose(convert_start_n) && auto_powerdown_mode &&
        powered_down |-> ##[1:5] !powered_down) else $error("no wake on start rise");
endmodule

bind adcpp_port_ctrl adcpp_port_checker #(.TAIL_CYC(TAIL_CYC)) adcpp_port_checker_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .word_mode(word_mode),
    .chip_select_n(chip_select_n), .read_n(read_n), .convert_start_n(convert_start_n),
    .auto_powerdown_mode(auto_powerdown_mode), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .busy(busy), .sampler_track(sampler_track),
    .powered_down(powered_down), .control_word(control_word)
);

// ===== test/testbench.sv
// Self-checking bench for the parallel-port conversion controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset_n, word_mode, chip_select_n, read_n, write_n;
    logic        convert_start_n, conversion_clock_in, auto_powerdown_mode;
    logic        busy, sampler_track, powered_down;
    logic [1:0]  conv_channel_in;
    logic [11:0] data_in, data_out, data_oe, conv_result_in, control_word, q;
    int          err_total, cmp_count;

    adcpp_port_ctrl adcpp_port_ctrl_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .word_mode(word_mode),
        .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
        .convert_start_n(convert_start_n), .conversion_clock_in(conversion_clock_in),
        .auto_powerdown_mode(auto_powerdown_mode), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .conv_result_in(conv_result_in), .conv_channel_in(conv_channel_in),
        .busy(busy), .sampler_track(sampler_track), .powered_down(powered_down),
        .control_word(control_word));
    adcpp_host_model adcpp_host_model_i (
        .sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .word_mode(word_mode),
        .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
        .convert_start_n(convert_start_n), .conversion_clock_in(conversion_clock_in),
        .data_in(data_in));
    // ----------------------------------------
    // Clock, compare and closing helpers
    // ----------------------------------------
    always #20 sys_clk = ~sys_clk;
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_busy_low();
        for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge sys_clk);
        chk({11'h0, busy}, 12'h000);
        if (busy !== 1'b0) stop_test();
    endtask
    task automatic t_reset();
        chk(data_oe, 12'h000);
        chk({9'h0, busy, sampler_track, powered_down}, 12'h002);
        $display("test reset done");
    endtask
    task automatic t_write();
        adcpp_host_model_i.xfer(1'b1, 1'b1, 12'hA5C, q);
        chk(control_word, 12'hA5C);
        adcpp_host_model_i.xfer(1'b0, 1'b1, 12'h03E, q);
        chk(control_word, 12'hA3E);
        adcpp_host_model_i.xfer(1'b0, 1'b1, 12'h109, q);
        chk(control_word, 12'h93E);
        $display("test write done");
    endtask
    // Full conversion with a burst clock, then word and both byte reads
    task automatic t_convert(input logic [11:0] res, input logic [1:0] ch, input int half,
                             input logic auto);
        conv_result_in = res;
        conv_channel_in = ch;
        auto_powerdown_mode = auto;
        adcpp_host_model_i.set_start(1'b0);
        adcpp_host_model_i.wait_cyc(6);
        chk({10'h0, busy, sampler_track}, 12'h002);
        adcpp_host_model_i.clk_rises(12, half);
        chk({10'h0, busy, sampler_track}, 12'h002);
        adcpp_host_model_i.clk_rises(1, half);
        wait_busy_low();
        adcpp_host_model_i.wait_cyc(2);
        chk({10'h0, powered_down, sampler_track}, {10'h0, auto, 1'b1});
        adcpp_host_model_i.set_start(1'b1);
        adcpp_host_model_i.wait_cyc(6);
        chk({11'h0, powered_down}, 12'h000);
        adcpp_host_model_i.xfer(1'b1, 1'b0, 12'h000, q);
        chk(q, res);
        adcpp_host_model_i.xfer(1'b0, 1'b0, 12'h000, q);
        chk(q, {4'h0, res[7:0]});
        adcpp_host_model_i.xfer(1'b0, 1'b0, 12'h100, q);
        chk(q, {6'h00, ch, res[11:8]});
        $display("test convert done");
    endtask
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        err_total = 0;
        cmp_count = 0;
        auto_powerdown_mode = 1'b0;
        conv_result_in = 12'h000;
        conv_channel_in = 2'b00;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_reset();
        t_write();
        t_convert(12'hB4D, 2'b10, 2, 1'b0);
        t_convert(12'h3F0, 2'b01, 3, 1'b1);
        stop_test();
    end
endmodule
